// >>> src/user_pin_passthrough_switch_ctrl.sv
// serial register slave, user-pin pass-through router and switch control
`timescale 1ns/1ps

module user_pin_passthrough_switch_ctrl #(
   parameter int PINS = 4
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   output logic dout,
   output logic dout_oe,
   input wire logic [PINS-1:0] user_pin_in,
   output logic [PINS-1:0] user_pin_out,
   output logic [PINS-1:0] user_pin_oe,
   input wire logic [PINS*4-1:0] pin_mode_field,
   input wire logic [PINS-1:0] assert_polarity_bit,
   input wire logic [PINS-1:0] pin_level_bit,
   input wire user_pin_pt_pkg::pwm_ctrl_s pwm_ctrl,
   output user_pin_pt_pkg::switch_state_s switch_state,
   output logic [PINS-1:0] pin_rise_flag,
   output logic [PINS-1:0] pin_fall_flag,
   output logic [PINS-1:0] pin_level_q,
   output logic passthru_active
);

   // -------------------------------------------------------------------
   // serial pin synchronisers
   // -------------------------------------------------------------------
   logic [2:0] cs_sync_q;
   logic [2:0] clk_sync_q;
   logic [1:0] din_sync_q;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cs_sync_q <= 3'h7;
         clk_sync_q <= 3'h0;
         din_sync_q <= 2'h0;
      end
      else
      begin
         cs_sync_q <= {cs_sync_q[1:0], cs_n};
         clk_sync_q <= {clk_sync_q[1:0], sclk};
         din_sync_q <= {din_sync_q[0], din};
      end
   end

   wire cs_high = cs_sync_q[1];
   wire cs_rise = cs_sync_q[1] & ~cs_sync_q[2];
   wire cs_fall = ~cs_sync_q[1] & cs_sync_q[2];
   wire sclk_rise = clk_sync_q[1] & ~clk_sync_q[2];
   wire sclk_fall = ~clk_sync_q[1] & clk_sync_q[2];
   wire din_bit = din_sync_q[1];

   // -------------------------------------------------------------------
   // user pin synchronisers and edge tracking
   // -------------------------------------------------------------------
   logic [PINS-1:0] pin_meta_q;
   logic [PINS-1:0] pin_prev_q;

   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi++)
      begin : g_pin_sync
         // tracking never stops, forwarding included
         always_ff @(posedge sys_clk or negedge nrst)
         begin
            if (!nrst)
            begin
               pin_meta_q[gi] <= 1'h0;
               pin_level_q[gi] <= 1'h0;
               pin_prev_q[gi] <= 1'h0;
               pin_rise_flag[gi] <= 1'h0;
               pin_fall_flag[gi] <= 1'h0;
            end
            else
            begin
               pin_meta_q[gi] <= user_pin_in[gi];
               pin_level_q[gi] <= pin_meta_q[gi];
               pin_prev_q[gi] <= pin_level_q[gi];
               pin_rise_flag[gi] <= pin_level_q[gi] & ~pin_prev_q[gi];
               pin_fall_flag[gi] <= ~pin_level_q[gi] & pin_prev_q[gi];
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // serial frame engine
   // -------------------------------------------------------------------
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic [7:0] cmd_q;
   logic [7:0] rd_shift_q;
   logic [7:0] passthru_q;
   logic [7:0] switch_q;
   logic pt_armed_q;
   logic act_q;

   wire [7:0] new_byte = {shift_q[6:0], din_bit};
   // bits clocked in during forwarding belong to the far device
   wire take_bit = sclk_rise & ~cs_high & ~act_q;
   wire cmd_done = take_bit & (bit_cnt_q == user_pin_pt_pkg::CMD_LAST_BIT);
   wire frame_done = take_bit & (bit_cnt_q == user_pin_pt_pkg::FRAME_LAST_BIT);
   wire is_write = cmd_q[user_pin_pt_pkg::CMD_RW_BIT] != user_pin_pt_pkg::CMD_READ;
   wire commit = frame_done & is_write;
   wire wr_passthru = commit & (cmd_q[6:0] == user_pin_pt_pkg::ADDR_PASSTHRU);
   wire wr_switch = commit & (cmd_q[6:0] == user_pin_pt_pkg::ADDR_SWITCH);
   wire shift_out = sclk_fall & ~cs_high & ~act_q
      & (bit_cnt_q >= user_pin_pt_pkg::DATA_FIRST_SHIFT);

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         cmd_q <= 8'h00;
      end
      else if (cs_high)
         bit_cnt_q <= 4'h0;
      else if (take_bit)
      begin
         shift_q <= new_byte;
         bit_cnt_q <= bit_cnt_q + 4'h1;
         if (cmd_done)
            cmd_q <= new_byte;
      end
   end

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         passthru_q <= user_pin_pt_pkg::PASSTHRU_RESET;
         switch_q <= user_pin_pt_pkg::SWITCH_RESET;
      end
      else
      begin
         if (wr_passthru)
            passthru_q <= new_byte & user_pin_pt_pkg::PASSTHRU_MASK;
         if (wr_switch)
            switch_q <= new_byte & user_pin_pt_pkg::SWITCH_MASK;
      end
   end

   user_pin_pt_pkg::route_en_s route_en;
   assign route_en = passthru_q[user_pin_pt_pkg::PT_PIN4_BIT
      :user_pin_pt_pkg::PT_PIN1_BIT];

   // -------------------------------------------------------------------
   // forwarding window
   // -------------------------------------------------------------------
   // arm on the write, open only once chip select closes the frame
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pt_armed_q <= 1'h0;
         act_q <= 1'h0;
      end
      else
      begin
         if (wr_passthru)
            pt_armed_q <= 1'h1;
         else if (cs_rise)
            pt_armed_q <= 1'h0;
         if (cs_fall)
            act_q <= 1'h0;
         else if (cs_rise & pt_armed_q)
            act_q <= 1'h1;
      end
   end

   assign passthru_active = act_q;

   // raw chip select cuts the route the moment it falls
   wire route_live = act_q & cs_n;

   // -------------------------------------------------------------------
   // read path
   // -------------------------------------------------------------------
   wire [7:0] state_byte = {pin_level_q, switch_state.buf_closed,
      switch_state.throw1_no_closed, switch_state.throw2_no_closed, act_q};
   wire [6:0] rd_addr = new_byte[6:0];
   wire [7:0] rd_data =
      (rd_addr == user_pin_pt_pkg::ADDR_PASSTHRU) ? passthru_q :
      (rd_addr == user_pin_pt_pkg::ADDR_SWITCH) ? switch_q :
      (rd_addr == user_pin_pt_pkg::ADDR_STATE) ? state_byte : 8'h00;
   wire rd_load = cmd_done & (new_byte[user_pin_pt_pkg::CMD_RW_BIT]
      == user_pin_pt_pkg::CMD_READ);

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         rd_shift_q <= 8'h00;
      else if (cs_high)
         rd_shift_q <= 8'h00;
      else if (rd_load)
         rd_shift_q <= rd_data;
      else if (shift_out)
         rd_shift_q <= {rd_shift_q[6:0], 1'h0};
   end

   wire pin1_fwd = route_live & route_en.pin1_dout_route_en;
   assign dout = pin1_fwd ? user_pin_in[0] : rd_shift_q[7];
   assign dout_oe = pin1_fwd | ~cs_high;

   // -------------------------------------------------------------------
   // user pin drive
   // -------------------------------------------------------------------
   function automatic logic [3:0] mode_of(input logic [PINS*4-1:0] f,
                                          input int i);
      mode_of = f[i*4 +: 4];
   endfunction

   function automatic logic pin_vote(input logic [PINS*4-1:0] f,
                                     input logic [PINS-1:0] lvl,
                                     input logic [PINS-1:0] pol,
                                     input logic [3:0] code);
      pin_vote = 1'h0;
      for (int i = 0; i < PINS; i++)
      begin
         // asserted when level equals polarity others give 0
         pin_vote = pin_vote | ((mode_of(f, i) == code)
            & (lvl[i] == pol[i]));
      end
   endfunction

   logic [PINS-1:0] base_out;
   logic [PINS-1:0] base_oe;
   generate
      for (gi = 0; gi < PINS; gi++)
      begin : g_pin_base
         wire is_gpo = mode_of(pin_mode_field, gi) == user_pin_pt_pkg::MODE_GPO;
         assign base_out[gi] = is_gpo & pin_level_bit[gi];
         assign base_oe[gi] = is_gpo;
      end
   endgenerate

   wire fwd3 = route_live & route_en.pin3_clk_route_en;
   wire fwd2 = route_live & route_en.pin2_din_route_en;
   wire en4 = route_en.pin4_cs_route_en;

   assign user_pin_out[3] = en4 ? ~route_live : base_out[3];
   assign user_pin_oe[3] = en4 | base_oe[3];
   assign user_pin_out[2] = fwd3 ? sclk : base_out[2];
   assign user_pin_oe[2] = fwd3 | base_oe[2];
   assign user_pin_out[1] = fwd2 ? din : base_out[1];
   assign user_pin_oe[1] = fwd2 | base_oe[1];
   assign user_pin_out[0] = base_out[0];
   assign user_pin_oe[0] = base_oe[0] & ~pin1_fwd;

   // -------------------------------------------------------------------
   // switch control
   // -------------------------------------------------------------------
   wire buf_pins = pin_vote(pin_mode_field, pin_level_q,
      assert_polarity_bit, user_pin_pt_pkg::MODE_BUF_IN);
   wire t1_pins = pin_vote(pin_mode_field, pin_level_q,
      assert_polarity_bit, user_pin_pt_pkg::MODE_THROW1_IN);
   wire t2_pins = pin_vote(pin_mode_field, pin_level_q,
      assert_polarity_bit, user_pin_pt_pkg::MODE_THROW2_IN);
   // deselected PWM terms are zero
   wire pwm_buf = pwm_ctrl.pwm_on ? pwm_ctrl.pwm_high_buf_sel
      : pwm_ctrl.pwm_low_buf_sel;
   wire pwm_t1 = pwm_ctrl.pwm_on & pwm_ctrl.pwm_throw1_sel;
   wire pwm_t2 = pwm_ctrl.pwm_on & pwm_ctrl.pwm_throw2_sel;
   wire buf_drive = switch_q[user_pin_pt_pkg::SW_BUF_BIT] | buf_pins
      | pwm_buf;
   wire t1_drive = switch_q[user_pin_pt_pkg::SW_T1_DRV_BIT] | t1_pins
      | pwm_t1;
   wire t2_drive = switch_q[user_pin_pt_pkg::SW_T2_DRV_BIT] | t2_pins
      | pwm_t2;
   wire t1_tog = switch_q[user_pin_pt_pkg::SW_T1_TOG_BIT];
   wire t2_tog = switch_q[user_pin_pt_pkg::SW_T2_TOG_BIT];

   user_pin_pt_pkg::switch_state_s sw_d;
   // toggle mode swaps the normally-closed contact only
   assign sw_d = '{buf_closed: buf_drive,
                   throw1_nc_closed: t1_drive ^ t1_tog,
                   throw1_no_closed: t1_drive,
                   throw2_nc_closed: t2_drive ^ t2_tog,
                   throw2_no_closed: t2_drive};

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         switch_state <= '0;
      else
         switch_state <= sw_d;
   end

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   sequence cs_rise_seq;
      cs_sync_q[1] && !cs_sync_q[2];
   endsequence
   sequence cs_fall_seq;
      !cs_sync_q[1] && cs_sync_q[2];
   endsequence

   AST_PT_START: assert property (@(posedge sys_clk) disable iff (!nrst)
      (cs_rise_seq and pt_armed_q) |=> act_q)
      else $error("forwarding did not start");
   AST_PT_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
      act_q && cs_sync_q[1] ##1 cs_sync_q[1] |-> act_q)
      else $error("forwarding dropped while select high");
   AST_PT_END: assert property (@(posedge sys_clk) disable iff (!nrst)
      cs_fall_seq |=> !act_q ##1 !act_q)
      else $error("forwarding outlived select fall");
   AST_PIN4: assert property (@(posedge sys_clk) disable iff (!nrst)
      en4 && act_q && cs_n |-> !user_pin_out[3] && user_pin_oe[3])
      else $error("pin 4 not low during forwarding");
   AST_PIN3: assert property (@(posedge sys_clk) disable iff (!nrst)
      fwd3 |-> user_pin_out[2] == sclk && user_pin_oe[2])
      else $error("pin 3 not carrying serial clock");
   AST_PIN2: assert property (@(posedge sys_clk) disable iff (!nrst)
      fwd2 |-> user_pin_out[1] == din && user_pin_oe[1])
      else $error("pin 2 not carrying serial data");
   AST_DOUT: assert property (@(posedge sys_clk) disable iff (!nrst)
      pin1_fwd |-> dout == user_pin_in[0] && dout_oe && !user_pin_oe[0])
      else $error("data out not from pin 1");
   AST_GPO: assert property (@(posedge sys_clk) disable iff (!nrst)
      !act_q && !en4 && mode_of(pin_mode_field, 3) == user_pin_pt_pkg::MODE_GPO
      |-> user_pin_out[3] == pin_level_bit[3] && user_pin_oe[3])
      else $error("pin 4 ignores its level bit");
   AST_BUF_REG: assert property (@(posedge sys_clk) disable iff (!nrst)
      switch_q[user_pin_pt_pkg::SW_BUF_BIT] [*2] |-> switch_state.buf_closed)
      else $error("buffer switch open with its bit set");
   AST_THROW_TOG: assert property (@(posedge sys_clk) disable iff (!nrst)
      ##1 (switch_state.throw1_nc_closed != switch_state.throw1_no_closed)
      == $past(t1_tog))
      else $error("throw 1 contacts disagree with toggle bit");
   AST_EDGE: assert property (@(posedge sys_clk) disable iff (!nrst)
      pin_rise_flag[0] |-> $past(pin_level_q[0]) && !pin_fall_flag[0])
      else $error("rise flag without pin rise");

endmodule

// >>> shared/user_pin_pt_pkg.sv
// constants, register map and carrier types for the pass-through and switch block
package user_pin_pt_pkg;

   // -------------------------------------------------------------------
   // serial frame layout
   // -------------------------------------------------------------------
   localparam int FRAME_BITS = 16;
   localparam logic [3:0] CMD_LAST_BIT = 4'h7;
   localparam logic [3:0] DATA_FIRST_SHIFT = 4'h9;
   localparam logic [3:0] FRAME_LAST_BIT = 4'hF;
   localparam int CMD_RW_BIT = 7;
   localparam logic CMD_READ = 1'h1;

   // -------------------------------------------------------------------
   // register addresses (seven-bit field of the command byte)
   // -------------------------------------------------------------------
   localparam logic [6:0] ADDR_PASSTHRU = 7'h10;
   localparam logic [6:0] ADDR_SWITCH = 7'h11;
   localparam logic [6:0] ADDR_STATE = 7'h12;

   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int PT_PIN4_BIT = 7;
   localparam int PT_PIN3_BIT = 6;
   localparam int PT_PIN2_BIT = 5;
   localparam int PT_PIN1_BIT = 4;
   localparam int SW_BUF_BIT = 7;
   localparam int SW_T1_TOG_BIT = 5;
   localparam int SW_T1_DRV_BIT = 4;
   localparam int SW_T2_TOG_BIT = 3;
   localparam int SW_T2_DRV_BIT = 2;

   // -------------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------------
   localparam logic [7:0] PASSTHRU_RESET = 8'h00;
   localparam logic [7:0] SWITCH_RESET = 8'h00;
   // writable bits; the rest always read back 0
   localparam logic [7:0] PASSTHRU_MASK = 8'hF0;
   localparam logic [7:0] SWITCH_MASK = 8'hBC;

   // -------------------------------------------------------------------
   // user pin mode codes
   // -------------------------------------------------------------------
   localparam logic [3:0] MODE_GPI = 4'h0;
   localparam logic [3:0] MODE_GPO = 4'h1;
   localparam logic [3:0] MODE_BUF_IN = 4'h2;
   localparam logic [3:0] MODE_THROW1_IN = 4'h4;
   localparam logic [3:0] MODE_THROW2_IN = 4'h5;

   typedef struct packed {
      logic pin4_cs_route_en;
      logic pin3_clk_route_en;
      logic pin2_din_route_en;
      logic pin1_dout_route_en;
   } route_en_s;

   typedef struct packed {
      logic buf_closed;
      logic throw1_nc_closed;
      logic throw1_no_closed;
      logic throw2_nc_closed;
      logic throw2_no_closed;
   } switch_state_s;

   typedef struct packed {
      logic pwm_on;
      logic pwm_high_buf_sel;
      logic pwm_low_buf_sel;
      logic pwm_throw1_sel;
      logic pwm_throw2_sel;
   } pwm_ctrl_s;

endpackage

// >>> dv/serial_host_model.sv
// host processor model driving the four-wire serial register bus
`timescale 1ns/1ps

module serial_host_model (
   output logic cs_n,
   output logic sclk,
   output logic din,
   input wire logic dout
);
   localparam realtime HALF = 62.5;

   // serial clock idles low and only toggles inside the shift task
   initial
   begin
      cs_n = 1'h1;
      sclk = 1'h0;
      din = 1'h0;
   end

   // -------------------------------------------------------------------
   // bit shifting, chip select left as it is
   // -------------------------------------------------------------------
   task automatic shift(input logic [15:0] tx, output logic [7:0] rx);
      for (int i = 15; i >= 0; i--)
      begin
         din = tx[i];
         #HALF sclk = 1'h1;
         if (i < 8)
            rx[i] = dout;
         #HALF sclk = 1'h0;
      end
      // released data line must not keep showing the last bit
      din = ~din;
   endtask

   // -------------------------------------------------------------------
   // one register frame, chip select left high afterwards
   // -------------------------------------------------------------------
   task automatic frame(input logic [7:0] cmd, input logic [7:0] data,
      output logic [7:0] rx);
      cs_n = 1'h0;
      #HALF shift({cmd, data}, rx);
      #HALF cs_n = 1'h1;
      // chip select stays high long enough for the synchroniser
      #60;
   endtask
endmodule

// >>> dv/user_pin_passthrough_switch_ctrl_bench.sv
// self-checking bench for the pass-through router and switch control
`timescale 1ns/1ps

module user_pin_passthrough_switch_ctrl_bench;
   logic sys_clk = 1'h0;
   logic nrst = 1'h0;
   logic cs_n, sclk, din, dout, dout_oe, passthru_active;
   logic [3:0] user_pin_in = 4'h0;
   logic [3:0] user_pin_out, user_pin_oe;
   logic [15:0] pin_mode_field = 16'h0000;
   logic [3:0] assert_polarity_bit = 4'h0;
   logic [3:0] pin_level_bit = 4'h0;
   user_pin_pt_pkg::pwm_ctrl_s pwm_ctrl = '0;
   user_pin_pt_pkg::switch_state_s switch_state;
   logic [3:0] pin_rise_flag, pin_fall_flag, pin_level_q;
   logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5};
   int n_fail = 0;
   int num_checks = 0;
   int nflag = 0;
   int nfall = 0;

   always #5 sys_clk = ~sys_clk;

   // flags launch on the rising edge; count them mid-cycle
   always @(negedge sys_clk)
   begin
      if (pin_rise_flag[0] === 1'h1)
         nflag++;
      if (pin_fall_flag[0] === 1'h1)
         nfall++;
   end

   user_pin_passthrough_switch_ctrl dut (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .cs_n(cs_n),
      .sclk(sclk),
      .din(din),
      .dout(dout),
      .dout_oe(dout_oe),
      .user_pin_in(user_pin_in),
      .user_pin_out(user_pin_out),
      .user_pin_oe(user_pin_oe),
      .pin_mode_field(pin_mode_field),
      .assert_polarity_bit(assert_polarity_bit),
      .pin_level_bit(pin_level_bit),
      .pwm_ctrl(pwm_ctrl),
      .switch_state(switch_state),
      .pin_rise_flag(pin_rise_flag),
      .pin_fall_flag(pin_fall_flag),
      .pin_level_q(pin_level_q),
      .passthru_active(passthru_active)
   );

   serial_host_model host (
      .cs_n(cs_n),
      .sclk(sclk),
      .din(din),
      .dout(dout)
   );

   // -------------------------------------------------------------------
   // comparison and bus tasks
   // -------------------------------------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask

   task automatic chk_sw(input user_pin_pt_pkg::switch_state_s got,
      input user_pin_pt_pkg::switch_state_s exp);
      chk_byte({3'h0, got}, {3'h0, exp});
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wr(input logic [6:0] addr, input logic [7:0] data);
      logic [7:0] rx;
      host.frame({1'h0, addr}, data, rx);
   endtask

   task automatic rd(input logic [6:0] addr, input logic [7:0] exp);
      logic [7:0] rx;
      host.frame({1'h1, addr}, 8'h00, rx);
      chk_byte(rx, exp);
   endtask

   // forwarding view with all pins GPO except pin 1
   task automatic chk_pt(input logic [7:0] en);
      chk_bit(user_pin_out[3], en[7] ? 1'h0 : pin_level_bit[3]);
      chk_bit(user_pin_out[2], en[6] ? sclk : pin_level_bit[2]);
      chk_bit(user_pin_out[1], en[5] ? din : pin_level_bit[1]);
      chk_bit(dout_oe, en[4]);
      if (en[4])
         chk_bit(dout, user_pin_in[0]);
   endtask

   // -------------------------------------------------------------------
   // expectation functions
   // -------------------------------------------------------------------
   function automatic logic vote(input logic [3:0] code);
      logic v;
      v = 1'h0;
      for (int i = 0; i < 4; i++)
         if (pin_mode_field[4*i +: 4] == code &&
            user_pin_in[i] == assert_polarity_bit[i])
            v = 1'h1;
      return v;
   endfunction

   function automatic user_pin_pt_pkg::switch_state_s exp_sw(
      input logic [7:0] r);
      logic b, d1, d2;
      b = r[7] | vote(4'h2) | (pwm_ctrl.pwm_on ?
         pwm_ctrl.pwm_high_buf_sel : pwm_ctrl.pwm_low_buf_sel);
      d1 = r[4] | vote(4'h4) | (pwm_ctrl.pwm_on & pwm_ctrl.pwm_throw1_sel);
      d2 = r[2] | vote(4'h5) | (pwm_ctrl.pwm_on & pwm_ctrl.pwm_throw2_sel);
      return {b, d1 ^ r[5], d1, d2 ^ r[3], d2};
   endfunction

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial
   begin
      logic [7:0] r;
      logic [7:0] rx;
      int rises;
      int base;
      int falls;
      int fbase;
      logic [4:0] e;
      r = 8'($urandom(1));
      fork
         begin
            #400us;
            n_fail++;
            complete_run();
         end
      join_none
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk) nrst = 1'h1;
      repeat (4) @(negedge sys_clk);
      chk_sw(switch_state, '0);
      rd(7'h10, 8'h00);
      rd(7'h11, 8'h00);
      wr(7'h11, 8'hFF);
      rd(7'h11, 8'hBC);
      wr(7'h33, 8'hFF);
      rd(7'h33, 8'h00);
      // first pass is the all-open corner: pins deasserted and unassigned
      for (int k = 0; k < 40; k++)
      begin
         r = (k == 0) ? 8'h00 : 8'($urandom()) & 8'hBC;
         wr(7'h11, r);
         @(negedge sys_clk);
         for (int i = 0; i < 4; i++)
            pin_mode_field[4*i +: 4] = (k == 0) ? 4'h0 :
               codes[$urandom_range(4)];
         assert_polarity_bit = 4'($urandom());
         user_pin_in = (k == 0) ? ~assert_polarity_bit : 4'($urandom());
         pin_level_bit = 4'($urandom());
         pwm_ctrl = (k == 0) ? '0 : 5'($urandom());
         repeat (8) @(negedge sys_clk);
         chk_sw(switch_state, exp_sw(r));
         chk_sw(switch_state, exp_sw(r));
         chk_sw(switch_state, exp_sw(r));
         for (int i = 0; i < 4; i++)
         begin
            chk_bit(user_pin_oe[i], pin_mode_field[4*i +: 4] == 4'h1);
            if (pin_mode_field[4*i +: 4] == 4'h1)
               chk_bit(user_pin_out[i], pin_level_bit[i]);
         end
         e = exp_sw(r);
         chk_byte({4'h0, pin_level_q}, {4'h0, user_pin_in});
         rd(7'h12, {user_pin_in, e[4], e[2], e[0], 1'h0});
      end
      pin_mode_field = 16'h1110;
      for (int k = 0; k < 2; k++)
      begin
         r = k ? 8'h60 : 8'hF0;
         pin_level_bit = 4'($urandom());
         wr(7'h10, r);
         repeat (6) @(negedge sys_clk);
         chk_bit(passthru_active, 1'h1);
         rises = 0;
         base = nflag;
         falls = 0;
         fbase = nfall;
         @(negedge sys_clk) #2;
         // downstream traffic with pin edges while chip select is high
         fork
            host.shift(16'($urandom()), rx);
            repeat (150)
            begin
               @(negedge sys_clk);
               r[0] = user_pin_in[0];
               user_pin_in = 4'($urandom());
               if (!r[0] && user_pin_in[0])
                  rises++;
               if (r[0] && !user_pin_in[0])
                  falls++;
               r[0] = 1'h0;
               #1 chk_pt(k ? 8'h60 : 8'hF0);
            end
         join
         r = k ? 8'h60 : 8'hF0;
         repeat (6) @(negedge sys_clk);
         chk_byte(8'(nflag - base), 8'(rises));
         chk_byte(8'(nfall - fbase), 8'(falls));
         chk_bit(passthru_active, 1'h1);
         fork
            rd(7'h10, r);
            begin
               // the read may already have lowered select in this step
               wait (cs_n === 1'h0);
               #1 chk_bit(user_pin_out[2], pin_level_bit[2]);
               chk_bit(user_pin_out[3], r[7] | pin_level_bit[3]);
            end
         join
         repeat (6) @(negedge sys_clk);
         chk_bit(passthru_active, 1'h0);
      end
      complete_run();
   end
endmodule
